// file: src/rsts_consts.svh
`ifndef RSTS_CONSTS_SVH
`define RSTS_CONSTS_SVH

// Register byte offsets
`define RSTS_CTRL_OFF 8'h00
`define RSTS_FUNC_CFG_OFF 8'h04
`define RSTS_STATUS_OFF 8'h08
`define RSTS_PHASE_OFF 8'h0c

// Control register fields
`define RSTS_CTRL_PIN_SHORT_BIT 0
`define RSTS_CTRL_START_BIT 8

// Reset values
`define RSTS_CTRL_RST 32'h0000_0000
`define RSTS_FUNC_CFG_RST 32'h0000_0000

// Default internal phase length in clock cycles
`define RSTS_PHASE_CYC_DEF 16'h0010

// AXI responses
`define RSTS_RESP_OKAY 2'h0
`define RSTS_RESP_SLVERR 2'h2

`endif

// file: src/rsts_pkg.sv
package rsts_pkg;

	// Reset sequence kinds
	typedef enum logic [5:0] {
		SEQ_NONE = 6'h01,
		SEQ_DESTR_BIST = 6'h02,
		SEQ_DESTR_NOBIST = 6'h04,
		SEQ_EXT_LONG_BIST = 6'h08,
		SEQ_FUNC_LONG = 6'h10,
		SEQ_FUNC_SHORT = 6'h20
	} rsts_seq_t;

	// Sequencer states
	typedef enum logic [3:0] {
		ST_RUN = 4'h1,
		ST_BUSY = 4'h2,
		ST_FINAL = 4'h4,
		ST_WAIT_PIN = 4'h8
	} rsts_state_t;

endpackage : rsts_pkg

// file: src/rsts_sync.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for asynchronous levels
module rsts_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_r; // First stage, read only by q

	// Both stages in one process
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_r <= INIT;
			q <= INIT;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end

endmodule : rsts_sync

`default_nettype wire

// file: src/rsts_seq.sv
// What this block does
// - Destructive source starts destructive sequence, NVM-selected self test
// - Destructive sources never start external or functional
// - Pin assert, long, self test: external long
// - Pin assert, long, no self test: functional long
// - Pin assert, short config: functional short
// - Pin starts sequence only from running released
// - Pin never starts destructive; low pin prolongs
// - Releasing pin marks sequence end; external low extends
// - Functional sequence shown on pin if every source trigger is enabled; software start never shown
// - Device only drives pin low, never high
// - Sequence ends entering run mode
// - Functional sequence from a source drives pin only when enabled; pin-started ones always drive it
`timescale 1ns/10ps
`default_nettype none
`include "rsts_consts.svh"

module rsts_seq #(
	parameter int NFUNC = 8,
	parameter int NDESTR = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Reset sources, asynchronous levels
	input wire logic [NDESTR-1:0] destr_src,
	input wire logic [NFUNC-1:0] func_src,
	// Nonvolatile configuration
	input wire logic nvm_self_test_en,
	// Reset pin, open drain
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe_n,
	// Sequencer status
	output logic run_operating_mode,
	output logic self_test_run,
	output rsts_pkg::rsts_seq_t seq_kind,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	import rsts_pkg::*;

	// Synchronised inputs
	logic [NDESTR-1:0] destr_s;
	logic [NFUNC-1:0] func_s;
	logic pin_s;
	logic nvm_s;

	// Pin idles high through the pull-up, so start released
	rsts_sync #(.WIDTH(NDESTR + NFUNC + 2), .INIT({{(NDESTR + NFUNC){1'b0}}, 2'b10})) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.d({destr_src, func_src, reset_pin_in, nvm_self_test_en}),
		.q({destr_s, func_s, pin_s, nvm_s})
	);

	// Whole state of the block
	typedef struct packed {
		rsts_state_t st;
		rsts_seq_t kind;
		logic [15:0] cnt;
		logic pin_low;
		logic run;
		logic bist;
		logic pin_prev;
		logic pin_short;
		logic [15:0] phase_cyc;
		logic [NFUNC-1:0] func_long;
		logic [NFUNC-1:0] func_pin_en;
		logic [NFUNC-1:0] last_src;
		logic aw_got;
		logic w_got;
		logic [7:0] aw_addr;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} rsts_state_all_t;

	rsts_state_all_t s_r;
	rsts_state_all_t s_nxt;

	// Per-source functional request classified by configuration
	logic [NFUNC-1:0] func_long_req;
	logic [NFUNC-1:0] func_short_req;

	genvar gi;
	generate
		for (gi = 0; gi < NFUNC; gi++) begin : g_func
			// Each source starts only the sequence its config selects
			assign func_long_req[gi] = func_s[gi] & s_r.func_long[gi];
			assign func_short_req[gi] = func_s[gi] & ~s_r.func_long[gi];
		end
	endgenerate

	// Next-state logic: sequencer and register slave
	always_comb begin
		logic pin_fall;
		logic sw_start;
		logic [31:0] wd;
		logic [31:0] ctrl_rd;
		pin_fall = 1'b0;
		sw_start = 1'b0;
		wd = 32'h0000_0000;
		ctrl_rd = 32'h0000_0000;
		s_nxt = s_r;
		pin_fall = s_r.pin_prev & ~pin_s;
		s_nxt.pin_prev = pin_s;

		// Write channel handshakes, either order
		if (s_r.awready && s_axi_awvalid) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
			s_nxt.awready = 1'b0;
		end
		if (s_r.wready && s_axi_wvalid) begin
			s_nxt.w_got = 1'b1;
			s_nxt.w_data = s_axi_wdata;
			s_nxt.w_strb = s_axi_wstrb;
			s_nxt.wready = 1'b0;
		end
		// Commit a write once both halves are held
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			wd = s_r.w_data;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = `RSTS_RESP_OKAY;
			unique case (s_r.aw_addr[7:2])
				6'(`RSTS_CTRL_OFF >> 2): begin
					if (s_r.w_strb[0]) begin
						s_nxt.pin_short = wd[`RSTS_CTRL_PIN_SHORT_BIT];
					end
					// Software request starts a long functional sequence that never drives the pin
					if (s_r.w_strb[1]) begin
						sw_start = wd[`RSTS_CTRL_START_BIT];
					end
				end
				6'(`RSTS_FUNC_CFG_OFF >> 2): begin
					// Low half: long select, high half: pin enable
					if (s_r.w_strb[0]) begin
						s_nxt.func_long = wd[NFUNC-1:0];
					end
					if (s_r.w_strb[2]) begin
						s_nxt.func_pin_en = wd[16 +: NFUNC];
					end
				end
				6'(`RSTS_PHASE_OFF >> 2): begin
					if (s_r.w_strb[0]) begin
						s_nxt.phase_cyc[7:0] = wd[7:0];
					end
					if (s_r.w_strb[1]) begin
						s_nxt.phase_cyc[15:8] = wd[15:8];
					end
				end
				default: begin
					s_nxt.bresp = `RSTS_RESP_SLVERR; // Status and unmapped
				end
			endcase
		end
		// Response taken, reopen the write channels
		if (s_r.bvalid && s_axi_bready) begin
			s_nxt.bvalid = 1'b0;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.awready = 1'b1;
			s_nxt.wready = 1'b1;
		end

		// Read channel: one cycle from address to data
		if (s_r.arready && s_axi_arvalid) begin
			s_nxt.arready = 1'b0;
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = `RSTS_RESP_OKAY;
			ctrl_rd[`RSTS_CTRL_PIN_SHORT_BIT] = s_r.pin_short;
			unique case (s_axi_araddr[7:2])
				6'(`RSTS_CTRL_OFF >> 2): s_nxt.rdata = ctrl_rd;
				6'(`RSTS_FUNC_CFG_OFF >> 2): begin
					s_nxt.rdata = 32'h0000_0000;
					s_nxt.rdata[NFUNC-1:0] = s_r.func_long;
					s_nxt.rdata[16 +: NFUNC] = s_r.func_pin_en;
				end
				6'(`RSTS_STATUS_OFF >> 2): begin
					// Sequence kind, state, run, self test, pin level
					s_nxt.rdata = {13'h0, pin_s, s_r.bist, s_r.run, 2'h0, s_r.st, 4'h0, s_r.kind};
				end
				6'(`RSTS_PHASE_OFF >> 2): s_nxt.rdata = {16'h0000, s_r.phase_cyc};
				default: begin
					s_nxt.rdata = 32'h0000_0000;
					s_nxt.rresp = `RSTS_RESP_SLVERR;
				end
			endcase
		end
		if (s_r.rvalid && s_axi_rready) begin
			s_nxt.rvalid = 1'b0;
			s_nxt.arready = 1'b1;
		end

		// Sequencer
		unique case (s_r.st)
			ST_RUN: begin
				// Destructive sources always win and ignore the pin
				if (|destr_s) begin
					s_nxt.kind = nvm_s ? SEQ_DESTR_BIST : SEQ_DESTR_NOBIST;
					s_nxt.bist = nvm_s;
					s_nxt.pin_low = 1'b1;
					s_nxt.st = ST_BUSY;
				end else if (pin_fall && s_r.run) begin
					// Only an edge seen while running counts
					s_nxt.st = ST_BUSY;
					s_nxt.pin_low = 1'b1;
					if (s_r.pin_short) begin
						s_nxt.kind = SEQ_FUNC_SHORT;
						s_nxt.bist = 1'b0;
					end else if (nvm_s) begin
						s_nxt.kind = SEQ_EXT_LONG_BIST;
						s_nxt.bist = 1'b1;
					end else begin
						s_nxt.kind = SEQ_FUNC_LONG;
						s_nxt.bist = 1'b0;
					end
				end else if (|func_long_req || sw_start) begin
					s_nxt.kind = SEQ_FUNC_LONG;
					s_nxt.bist = 1'b0;
					s_nxt.last_src = func_long_req;
					// Pin shown only if every trigger is enabled for it
					s_nxt.pin_low = ((func_long_req & ~s_r.func_pin_en) == '0) && !sw_start;
					s_nxt.st = ST_BUSY;
				end else if (|func_short_req) begin
					s_nxt.kind = SEQ_FUNC_SHORT;
					s_nxt.bist = 1'b0;
					s_nxt.last_src = func_short_req;
					s_nxt.pin_low = (func_short_req & ~s_r.func_pin_en) == '0;
					s_nxt.st = ST_BUSY;
				end
				s_nxt.cnt = 16'h0000;
				if (s_nxt.st == ST_BUSY) begin
					s_nxt.run = 1'b0;
				end
			end
			ST_BUSY: begin
				// Internal phases; short sequence uses a quarter length
				s_nxt.cnt = s_r.cnt + 16'h0001;
				if (s_r.cnt >= ((s_r.kind == SEQ_FUNC_SHORT) ? {2'h0, s_r.phase_cyc[15:2]} : s_r.phase_cyc)) begin
					s_nxt.cnt = 16'h0000;
					s_nxt.st = ST_FINAL;
				end
			end
			ST_FINAL: begin
				// End of internal sequence: let go of the pin
				s_nxt.pin_low = 1'b0;
				s_nxt.bist = 1'b0;
				s_nxt.st = ST_WAIT_PIN;
			end
			ST_WAIT_PIN: begin
				// Final phase stretched while the pin is held low outside
				if (pin_s) begin
					s_nxt.st = ST_RUN;
					s_nxt.run = 1'b1;
				end
			end
			default: begin
				s_nxt.st = ST_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r <= '{
				st: ST_WAIT_PIN,
				kind: SEQ_NONE,
				cnt: 16'h0000,
				pin_low: 1'b0,
				run: 1'b0,
				bist: 1'b0,
				pin_prev: 1'b1,
				pin_short: 1'(`RSTS_CTRL_RST >> `RSTS_CTRL_PIN_SHORT_BIT),
				phase_cyc: `RSTS_PHASE_CYC_DEF,
				func_long: '0,
				func_pin_en: '0,
				last_src: '0,
				aw_got: 1'b0,
				w_got: 1'b0,
				aw_addr: 8'h00,
				w_data: 32'h0000_0000,
				w_strb: 4'h0,
				awready: 1'b1,
				wready: 1'b1,
				bvalid: 1'b0,
				bresp: 2'h0,
				arready: 1'b1,
				rvalid: 1'b0,
				rdata: 32'h0000_0000,
				rresp: 2'h0
			};
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register; pin only ever pulled low
	assign reset_pin_out = 1'b0;
	assign reset_pin_oe_n = ~s_r.pin_low;
	assign run_operating_mode = s_r.run;
	assign self_test_run = s_r.bist;
	assign seq_kind = s_r.kind;
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rvalid = s_r.rvalid;

endmodule : rsts_seq

`default_nettype wire

// file: bench/rsts_seq_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module rsts_seq_monitor import rsts_pkg::*; #(
	parameter int NFUNC = 8,
	parameter int NDESTR = 4
) (
	// Clock, reset, sources
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [NDESTR-1:0] destr_src,
	// Pin and status
	input wire logic reset_pin_in,
	input wire logic reset_pin_out,
	input wire logic reset_pin_oe_n,
	input wire logic run_operating_mode,
	input wire logic self_test_run,
	input wire rsts_pkg::rsts_seq_t seq_kind,
	// Read channel
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_pin_only_low: assert property (reset_pin_out == 1'b0) else $error("pin driven high");
	a_drive_not_run: assert property (!reset_pin_oe_n |-> !run_operating_mode)
		else $error("pin driven in run mode");
	a_destr_kind: assert property (run_operating_mode && destr_src != '0
		|-> ##[1:6] seq_kind inside {SEQ_DESTR_BIST, SEQ_DESTR_NOBIST}) else $error("wrong destructive kind");
	a_bist_kind: assert property (self_test_run |-> seq_kind inside {SEQ_DESTR_BIST, SEQ_EXT_LONG_BIST})
		else $error("self test in wrong kind");
	// Run mode may only return once the pin has been seen high through the synchroniser
	a_run_needs_pin: assert property ($rose(run_operating_mode) |-> $past(reset_pin_in, 2))
		else $error("run before pin release");
	a_low_pin_hold: assert property (!reset_pin_in [*3] ##0 !run_operating_mode |=> !run_operating_mode)
		else $error("run while pin low");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
endmodule : rsts_seq_monitor
bind rsts_seq rsts_seq_monitor #(.NFUNC(NFUNC), .NDESTR(NDESTR)) i_mon (.clk(clk), .reset_n(reset_n),
	.destr_src(destr_src), .reset_pin_in(reset_pin_in), .reset_pin_out(reset_pin_out),
	.reset_pin_oe_n(reset_pin_oe_n), .run_operating_mode(run_operating_mode), .self_test_run(self_test_run),
	.seq_kind(seq_kind), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// file: bench/rsts_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
// External reset generator on the open-drain pin
module rsts_pin_model (
	// Clock
	input wire logic clk,
	// Device side of the pin
	input wire logic pin_out,
	input wire logic pin_oe_n,
	// Resolved level
	output logic pin_level
);
	// Generator pulls low while set
	logic ext_low = 1'b0;
	// Either party pulls low; otherwise the pull-up beats the weak pull-down
	assign pin_level = (!pin_oe_n) ? pin_out : !ext_low;
	// A hold longer than the sequence prolongs the final phase
	task pulse(input int n);
		ext_low <= 1'b1;
		repeat (n) @(posedge clk);
		ext_low <= 1'b0;
	endtask : pulse
endmodule : rsts_pin_model
`default_nettype wire

// file: bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsts_consts.svh"
module tb_top;
	import rsts_pkg::*;
	// Stimulus and observed signals
	logic clk, reset_n, nvm, pin, pin_out, oe_n, run, bist;
	logic [3:0] destr_src;
	logic [7:0] func_src, awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic [1:0] bresp, rresp, rsp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	rsts_seq_t kind;
	int errors = 0;
	int cmp_count = 0;
	int k, n;
	rsts_seq i_dut (.clk(clk), .reset_n(reset_n), .destr_src(destr_src), .func_src(func_src),
		.nvm_self_test_en(nvm), .reset_pin_in(pin), .reset_pin_out(pin_out), .reset_pin_oe_n(oe_n),
		.run_operating_mode(run), .self_test_run(bist), .seq_kind(kind), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	rsts_pin_model i_pin (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pin_level(pin));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Compare and count
	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("mismatch at %0t got %h expected %h", $time, g, e);
		end
	endtask : chk
	task complete_run();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	task fail();
		errors++;
		$display("mismatch at %0t wait ran out", $time);
		complete_run();
	endtask : fail
	// Bus write, address and data offered together; 3 marks no answer yet
	task axw(input logic [7:0] a, input logic [31:0] d);
		rsp = 2'h3;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50 && rsp == 2'h3; n++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) rsp = bresp;
		end
		bready <= 1'b0;
		if (rsp == 2'h3) fail();
		// Let an edge pass so a following call never reassigns bready in this step
		@(posedge clk);
	endtask : axw
	task axr(input logic [7:0] a);
		rsp = 2'h3;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50 && rsp == 2'h3; n++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				rsp = rresp;
				rd = rdata;
			end
		end
		rready <= 1'b0;
		if (rsp == 2'h3) fail();
		// Let an edge pass so a following call never reassigns rready in this step
		@(posedge clk);
	endtask : axr
	// Trigger t: 0 destructive, 1 pin, 2 functional source k, 3 software start with a pin pulse
	task run_case(input int t, input int nv, input int sh, input int ls, input int pe, input int hold);
		int drv, ek;
		ek = (t == 0) ? (nv ? 2 : 4) : (t == 1) ? (sh ? 32 : nv ? 8 : 16) : (t == 3 || ls != 0) ? 16 : 32;
		nvm <= nv[0];
		axw(`RSTS_CTRL_OFF, 32'(sh));
		axw(`RSTS_FUNC_CFG_OFF, 32'((pe << (16 + k)) | (ls << k)));
		repeat (4) @(posedge clk);
		if (t == 3) axw(`RSTS_CTRL_OFF, 32'(sh) | 32'h100);
		if (t == 0) destr_src <= 4'h1;
		if (t == 2) func_src <= 8'(1 << k);
		// In case 3 the pulse lands while the sequence runs and must start nothing
		if (t == 1 || t == 3) fork i_pin.pulse(hold); join_none
		for (n = 0; n < 20 && run; n++) @(posedge clk);
		destr_src <= '0;
		func_src <= '0;
		if (run) fail();
		@(posedge clk);
		chk(32'(kind), 32'(ek));
		chk(32'(bist), 32'(ek == 2 || ek == 8));
		drv = 0;
		for (n = 0; n < 900 && !run; n++) begin
			@(posedge clk);
			if (!oe_n) drv = 1;
		end
		if (!run) fail();
		if (t >= 2) chk(32'(drv), 32'(t == 2 && pe != 0));
		if (hold > 20) chk(32'(n >= hold - 4), 32'h1);
		// A pin pulse seen while not running must leave run mode alone afterwards
		if (t == 3) begin
			repeat (20) @(posedge clk);
			chk(32'(run), 32'h1);
		end
	endtask : run_case
	initial begin
		reset_n = 1'b0;
		destr_src = '0;
		func_src = '0;
		nvm = 1'b0;
		awaddr = '0;
		wdata = '0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = '0;
		arvalid = 1'b0;
		rready = 1'b0;
		void'($urandom(32'hb4bf));
		repeat (5) @(posedge clk);
		reset_n <= 1'b1;
		for (n = 0; n < 50 && !run; n++) @(posedge clk);
		if (!run) fail();
		// Register defaults, a refused write and an unmapped read
		axr(`RSTS_CTRL_OFF);
		chk(rd, `RSTS_CTRL_RST);
		axr(`RSTS_PHASE_OFF);
		chk(rd, 32'(`RSTS_PHASE_CYC_DEF));
		// Status after reset: pin high, run, no self test, run state, no sequence
		axr(`RSTS_STATUS_OFF);
		chk(rd, {13'h0, 1'b1, 1'b0, 1'b1, 2'h0, 4'(ST_RUN), 4'h0, 6'(SEQ_NONE)});
		axr(8'h40);
		chk({30'h0, rsp}, {30'h0, `RSTS_RESP_SLVERR});
		axw(`RSTS_STATUS_OFF, 32'h0);
		chk({30'h0, rsp}, {30'h0, `RSTS_RESP_SLVERR});
		// Short phase keeps each sequence brief
		axw(`RSTS_PHASE_OFF, 32'h8);
		k = $urandom % 8;
		run_case(0, 1, 0, 0, 0, 0);
		run_case(0, 0, 0, 0, 0, 0);
		run_case(1, 1, 0, 0, 0, 60);
		run_case(1, 0, 0, 0, 0, 4);
		run_case(1, 0, 1, 0, 0, 4);
		run_case(2, 0, 0, 1, 1, 0);
		run_case(2, 1, 0, 0, 0, 0);
		run_case(2, 0, 0, 0, 1, 0);
		run_case(3, 0, 0, 0, 0, 3);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
